// ==== core/pin_route.sv ====
module pin_route (
	input wire logic mux_mode,
	input wire logic [port_gpio_pkg::REG_IO-1:0] enable,
	input wire logic [port_gpio_pkg::REG_IO-1:0] direction,
	input wire logic [port_gpio_pkg::REG_IO-1:0] level,
	input wire port_gpio_pkg::pin_vec_type pin_in,
	input wire port_gpio_pkg::pin_vec_type mem_out,
	input wire port_gpio_pkg::pin_vec_type mem_oe,
	output port_gpio_pkg::pin_vec_type drive,
	output port_gpio_pkg::pin_vec_type drive_en,
	output logic [port_gpio_pkg::REG_IO-1:0] read_back
);
	import port_gpio_pkg::*;

	pin_vec_type gpio_en;
	pin_vec_type gpio_level;

	// ----------------------------------------------------------------
	// Pin ownership
	// ----------------------------------------------------------------
	// Pins above the register range have no enable bit and stay floating in GPIO mode.
	always_comb begin
		gpio_en = pin_vec_type'(enable & direction); // [R7] [R8] [R9] [R15]
		gpio_level = pin_vec_type'(level);
		if (mux_mode == MUX_MEMORY_MODE) begin
			drive = mem_out; // [R2] [R10]
			drive_en = mem_oe; // [R2] [R10]
		end else begin
			drive = gpio_level & gpio_en; // [R14]
			drive_en = gpio_en; // [R1] [R6]
		end
		for (int i = 0; i < REG_IO; i++) begin
			read_back[i] = direction[i] ? level[i] : pin_in[i]; // [R11] [R14]
		end
	end

endmodule // pin_route

// ==== core/port_gpio.sv ====
module port_gpio (
	input wire logic clk,
	input wire logic rst,
	input wire logic port_mux_mode,
	input wire port_gpio_pkg::bus_req_type bus_req,
	output port_gpio_pkg::bus_rsp_type bus_rsp,
	input wire port_gpio_pkg::pin_bank_type pin_in,
	output port_gpio_pkg::pin_bank_type pin_out,
	output port_gpio_pkg::pin_bank_type pin_oe,
	input wire port_gpio_pkg::pin_bank_type mem_out,
	input wire port_gpio_pkg::pin_bank_type mem_oe,
	output port_gpio_pkg::pin_bank_type mem_in,
	output logic gpio_active
);
	import port_gpio_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [REG_IO-1:0] enable;
		logic [REG_IO-1:0] direction;
		logic [REG_IO-1:0] level;
		bus_rsp_type rsp;
		pin_vec_type drive;
		pin_vec_type drive_en;
		pin_vec_type mem_in;
		logic gpio_active;
	} state_type;

	state_type state;
	state_type next_state;

	pin_vec_type pin_in_vec;
	pin_vec_type route_drive;
	pin_vec_type route_drive_en;
	logic [REG_IO-1:0] read_back;
	logic write_enable;
	logic write_direction;
	logic write_level;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	function automatic logic hit(input logic [ADDR_WIDTH-1:0] addr, input logic [15:0] offset);
		hit = (addr == offset);
	endfunction

	function automatic logic [DATA_WIDTH-1:0] reg_read(
		input logic [ADDR_WIDTH-1:0] addr,
		input logic [REG_IO-1:0] enable,
		input logic [REG_IO-1:0] direction,
		input logic [REG_IO-1:0] back
	);
		if (hit(addr, ENABLE_LOW_OFFSET)) begin
			reg_read = enable; // [R12]
		end else if (hit(addr, DIRECTION_LOW_OFFSET)) begin
			reg_read = direction; // [R13]
		end else if (hit(addr, LEVEL_LOW_OFFSET)) begin
			reg_read = back; // [R11]
		end else begin
			reg_read = UNMAPPED_READ;
		end
	endfunction

	// The struct cast numbers the pins as I/O 45..0.
	assign pin_in_vec = pin_vec_type'(pin_in); // [R3] [R4]

	assign write_enable = bus_req.write && hit(bus_req.addr, ENABLE_LOW_OFFSET);
	assign write_direction = bus_req.write && hit(bus_req.addr, DIRECTION_LOW_OFFSET);
	assign write_level = bus_req.write && hit(bus_req.addr, LEVEL_LOW_OFFSET);

	// ----------------------------------------------------------------
	// Pin routing
	// ----------------------------------------------------------------
	pin_route route (
		.mux_mode(port_mux_mode),
		.enable(state.enable),
		.direction(state.direction),
		.level(state.level),
		.pin_in(pin_in_vec),
		.mem_out(pin_vec_type'(mem_out)),
		.mem_oe(pin_vec_type'(mem_oe)),
		.drive(route_drive),
		.drive_en(route_drive_en),
		.read_back(read_back)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	// A read in the same cycle as a write returns the value held before the write.
	always_comb begin
		next_state = state;
		if (write_enable) begin
			next_state.enable = bus_req.wdata; // [R5] [R12]
		end
		if (write_direction) begin
			next_state.direction = bus_req.wdata; // [R5] [R13]
		end
		if (write_level) begin
			next_state.level = bus_req.wdata; // [R5] [R11]
		end
		next_state.rsp.valid = bus_req.read;
		if (bus_req.read) begin
			next_state.rsp.rdata = reg_read(bus_req.addr, state.enable, state.direction, read_back);
		end else begin
			next_state.rsp.rdata = UNMAPPED_READ;
		end
		next_state.drive = route_drive; // [R14]
		next_state.drive_en = route_drive_en; // [R15]
		next_state.mem_in = pin_in_vec;
		next_state.gpio_active = (port_mux_mode == MUX_GPIO_MODE); // [R1]
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state.enable <= ENABLE_LOW_RESET; // [R12]
			state.direction <= DIRECTION_LOW_RESET; // [R13]
			state.level <= LEVEL_LOW_RESET;
			state.rsp <= '0;
			state.drive <= '0;
			state.drive_en <= '0;
			state.mem_in <= '0;
			state.gpio_active <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign bus_rsp = state.rsp;
	assign pin_out = pin_bank_type'(state.drive);
	assign pin_oe = pin_bank_type'(state.drive_en);
	assign mem_in = pin_bank_type'(state.mem_in);
	assign gpio_active = state.gpio_active;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	a_enable_write_store: assert property ( // [R12]
		write_enable |=> state.enable == $past(bus_req.wdata)
	) else $error("enable register did not take the written value");

	a_direction_write_store: assert property ( // [R13]
		write_direction |=> state.direction == $past(bus_req.wdata)
	) else $error("direction register did not take the written value");

	a_memory_mode_owns: assert property ( // [R2]
		port_mux_mode == MUX_MEMORY_MODE |=>
			pin_oe == $past(mem_oe) && pin_out == $past(mem_out)
	) else $error("memory mode pins not following the memory interface");

	a_enable_no_override: assert property ( // [R10]
		(port_mux_mode == MUX_MEMORY_MODE && state.enable != '0 && mem_oe == '0) |=> pin_oe == '0
	) else $error("enable bit drove a pin in memory mode");

	a_gpio_drive_gate: assert property ( // [R15]
		port_mux_mode == MUX_GPIO_MODE |=>
			state.drive_en == pin_vec_type'($past(state.enable) & $past(state.direction))
	) else $error("GPIO drive enable not equal to enable and direction");

	a_disabled_pin_float: assert property ( // [R6]
		(port_mux_mode == MUX_GPIO_MODE && state.enable == '0) |=> state.drive_en == '0
	) else $error("disabled pin is being driven");

	a_input_pin_undriven: assert property ( // [R8]
		(port_mux_mode == MUX_GPIO_MODE && state.direction == '0) |=> state.drive_en == '0
	) else $error("input pin is being driven");

	a_output_pin_level: assert property ( // [R14]
		port_mux_mode == MUX_GPIO_MODE |=>
			(state.drive & state.drive_en) == (pin_vec_type'($past(state.level)) & state.drive_en)
	) else $error("output pin level differs from data bit");

	a_level_read_back: assert property ( // [R11]
		(bus_req.read && hit(bus_req.addr, LEVEL_LOW_OFFSET)) |=>
			bus_rsp.valid && bus_rsp.rdata ==
			(($past(state.direction) & $past(state.level)) | (~$past(state.direction) & $past(pin_in_vec[REG_IO-1:0])))
	) else $error("data register read does not match pins and data bits");

	a_read_answer_once: assert property (
		bus_req.read |=> bus_rsp.valid ##1 ($past(bus_req.read) || !bus_rsp.valid)
	) else $error("read answer missing or held too long");

	a_unmapped_read_zero: assert property (
		(bus_req.read && !hit(bus_req.addr, ENABLE_LOW_OFFSET) && !hit(bus_req.addr, DIRECTION_LOW_OFFSET)
			&& !hit(bus_req.addr, LEVEL_LOW_OFFSET)) |=> bus_rsp.rdata == UNMAPPED_READ
	) else $error("unmapped read returned nonzero data");

	a_mode_status: assert property ( // [R1]
		$fell(port_mux_mode) |=> gpio_active ##1 gpio_active == !$past(port_mux_mode)
	) else $error("GPIO mode status does not follow the mux field");

	c_gpio_output: cover property (
		port_mux_mode == MUX_GPIO_MODE && write_direction ##1 write_enable ##2 state.drive_en[0]
	);

	c_input_read: cover property (
		bus_req.read && hit(bus_req.addr, LEVEL_LOW_OFFSET) && state.direction == '0 ##1 bus_rsp.valid
	);

	c_mode_switch: cover property (
		state.drive_en != '0 ##1 port_mux_mode == MUX_MEMORY_MODE
	);

endmodule // port_gpio

// ==== core/port_gpio_pkg.sv ====
// Contract
// [R1] Shared pins may act as general-purpose I/O only while mux mode is zero.
// [R2] With mux mode one, every shared pin carries its memory interface function.
// [R3] Address pins 21..18 are I/O 3..0; data pins 31..16 are I/O 19..4.
// [R4] Control 0..15 are I/O 20..35; host data I/O 43..36; host control I/O 44, 45.
// [R5] Enable, direction and data registers each hold one bit per pin; only the 16-bit low registers exist here, for I/O 15..0.
// [R6] Enable bit zero disables the general-purpose function and floats the pin.
// [R7] Enable bit one lets the pin work as general-purpose I/O.
// [R8] Direction bit zero makes the pin an input, undriven by this logic.
// [R9] Direction bit one makes the pin an output driven by this logic.
// [R10] Enable bits cannot override the bus selection; memory mode keeps the pins.
// [R11] Data register holds the level read from or written to each pin.
// [R12] Enable register low: 16-bit read/write at 0x4400, bits reset to zero.
// [R13] Direction register low: 16-bit read/write at 0x4401, bits reset to zero.
// [R14] Output pins drive their data bit; input pins read back the pin level.
// [R15] A pin is driven only with mux mode zero, enable one and direction one.
package port_gpio_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int TOTAL_IO = 46;
	localparam int REG_IO = 16;
	localparam int ADDR_WIDTH = 16;
	localparam int DATA_WIDTH = 16;

	// ----------------------------------------------------------------
	// Register map, word addresses on the peripheral bus
	// ----------------------------------------------------------------
	localparam logic [15:0] ENABLE_LOW_OFFSET = 16'h4400;
	localparam logic [15:0] DIRECTION_LOW_OFFSET = 16'h4401;
	localparam logic [15:0] LEVEL_LOW_OFFSET = 16'h4402;
	localparam logic [15:0] ENABLE_LOW_RESET = 16'h0000;
	localparam logic [15:0] DIRECTION_LOW_RESET = 16'h0000;
	localparam logic [15:0] LEVEL_LOW_RESET = 16'h0000;
	localparam logic [15:0] UNMAPPED_READ = 16'h0000;

	// ----------------------------------------------------------------
	// Mux mode field values
	// ----------------------------------------------------------------
	localparam logic MUX_GPIO_MODE = 1'b0;
	localparam logic MUX_MEMORY_MODE = 1'b1;

	typedef logic [TOTAL_IO-1:0] pin_vec_type;

	// Field order fixes the I/O numbering: the struct cast to a vector gives I/O 45..0.
	typedef struct packed {
		logic [1:0] host_control;
		logic [7:0] host_data;
		logic [15:0] control;
		logic [15:0] data_high;
		logic [3:0] addr_high;
	} pin_bank_type;

	typedef struct packed {
		logic [ADDR_WIDTH-1:0] addr;
		logic write;
		logic read;
		logic [DATA_WIDTH-1:0] wdata;
	} bus_req_type;

	typedef struct packed {
		logic valid;
		logic [DATA_WIDTH-1:0] rdata;
	} bus_rsp_type;

endpackage

// ==== tb/pin_partner.sv ====
module pin_partner (
	input wire logic clk,
	input wire port_gpio_pkg::pin_vec_type pin_out,
	input wire port_gpio_pkg::pin_vec_type pin_oe,
	input wire port_gpio_pkg::pin_vec_type ext_val,
	input wire port_gpio_pkg::pin_vec_type ext_en,
	output port_gpio_pkg::pin_vec_type pin_in
);
	timeunit 1ns;
	timeprecision 1ps;
	import port_gpio_pkg::*;
	// ----------------------------------------------------------------
	// Wire resolution
	// ----------------------------------------------------------------
	// A line that nobody drives toggles every cycle, so a float never reads as a stable level.
	pin_vec_type wander = '0;
	always @(posedge clk) begin
		wander <= ~wander;
	end
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en & wander);
endmodule // pin_partner

// ==== tb/tb_parallel_port_pin_gpio.sv ====
module tb_parallel_port_pin_gpio;
	timeunit 1ns;
	timeprecision 1ps;
	import port_gpio_pkg::*;
	logic clk, rst, port_mux_mode, gpio_active;
	bus_req_type bus_req;
	bus_rsp_type bus_rsp;
	pin_vec_type pin_in, pin_out, pin_oe, mem_out, mem_oe, mem_in, ext_val, ext_en;
	pin_bank_type bank;
	logic [15:0] rv;
	int n_mismatch = 0;
	int n_checks = 0;

	port_gpio dut (.clk(clk), .rst(rst), .port_mux_mode(port_mux_mode), .bus_req(bus_req), .bus_rsp(bus_rsp),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .mem_out(mem_out), .mem_oe(mem_oe),
		.mem_in(mem_in), .gpio_active(gpio_active));
	pin_partner ext (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val), .ext_en(ext_en),
		.pin_in(pin_in));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input string what, input logic [45:0] seen, input logic [45:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk);
		bus_req <= '{addr: a, write: 1'b1, read: 1'b0, wdata: d};
		@(posedge clk);
		bus_req.write <= 1'b0;
	endtask

	task automatic rdchk(input string what, input logic [15:0] a, input logic [15:0] exp);
		rv = 'x;
		@(posedge clk);
		bus_req <= '{addr: a, write: 1'b0, read: 1'b1, wdata: 16'h0000};
		@(posedge clk);
		bus_req.read <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			@(negedge clk);
			if (bus_rsp.valid === 1'b1) begin
				rv = bus_rsp.rdata;
				break;
			end
		end
		chk(what, {30'h0, rv}, {30'h0, exp});
	endtask

	task automatic settle;
		repeat (2) @(posedge clk);
		@(negedge clk);
	endtask

	task automatic conclude;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		#20us;
		n_mismatch++;
		conclude();
	end

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		rst = 1'b1;
		port_mux_mode = 1'b0;
		bus_req = '0;
		mem_out = '0;
		mem_oe = '0;
		ext_en = '1;
		bank = '{host_control: 2'h2, host_data: 8'h6b, control: 16'h9d1e, data_high: 16'h4c73, addr_high: 4'h9};
		ext_val = bank;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		chk("oe after reset", pin_oe, '0);
		rdchk("enable reset", 16'h4400, 16'h0000);
		rdchk("direction reset", 16'h4401, 16'h0000);
		wr(16'h4400, 16'hffff);
		settle;
		chk("all inputs float", pin_oe, '0);
		rdchk("input numbering", 16'h4402, {bank.data_high[11:0], bank.addr_high});
		rdchk("enable readback", 16'h4400, 16'hffff);
		wr(16'h4401, 16'h0f0f);
		wr(16'h4402, 16'h3c3c);
		settle;
		chk("oe gpio", pin_oe, {30'h0, 16'h0f0f});
		chk("out level", pin_out & pin_oe, {30'h0, 16'h0c0c});
		rdchk("mixed read", 16'h4402, 16'h0c0c | (ext_val[15:0] & 16'hf0f0));
		rdchk("direction readback", 16'h4401, 16'h0f0f);
		rdchk("unmapped read", 16'h4403, 16'h0000);
		wr(16'h4400, 16'h00ff);
		settle;
		chk("partial enable", pin_oe, {30'h0, 16'h000f});
		@(posedge clk);
		port_mux_mode <= 1'b1;
		mem_out <= 46'h2aaa_5555_1234;
		mem_oe <= 46'h3fff_0000_f0f0;
		settle;
		chk("memory oe", pin_oe, mem_oe);
		chk("memory out", pin_out, mem_out);
		chk("memory in", mem_in, (mem_oe & mem_out) | (~mem_oe & ext_val));
		chk("gpio inactive", {45'h0, gpio_active}, 46'h0);
		// Enabled output pins must stay released while the memory interface drives nothing.
		@(posedge clk);
		mem_oe <= '0;
		settle;
		chk("memory idle oe", pin_oe, '0);
		@(posedge clk);
		port_mux_mode <= 1'b0;
		settle;
		chk("gpio again", pin_oe, {30'h0, 16'h000f});
		chk("gpio active", {45'h0, gpio_active}, 46'h1);
		conclude();
	end
endmodule // tb_parallel_port_pin_gpio
